// ==== rtl/bfle_consts.svh ====
// Constants for the bit, flag and load execution unit: register offsets,
// command field positions, status flag positions, reset values, cycle counts.
// Assumes inclusion by bare name from every file that needs them.
`ifndef BFLE_CONSTS_SVH
`define BFLE_CONSTS_SVH

// ****************************************
// Register byte offsets on the APB window.
// ****************************************
`define BFLE_OFF_CMD 12'h000
`define BFLE_OFF_ARG 12'h004
`define BFLE_OFF_FLAGS 12'h008
`define BFLE_OFF_STAT 12'h00c
`define BFLE_GPR_PAGE 5'h01

// ****************************************
// Command word field positions.
// ****************************************
`define BFLE_CMD_OP_LSB 0
`define BFLE_CMD_RD_LSB 5
`define BFLE_CMD_RR_LSB 10
`define BFLE_CMD_BIT_LSB 15
`define BFLE_CMD_PTR_LSB 18
`define BFLE_CMD_MODE_LSB 20

// ****************************************
// Status flag bit positions and reset values.
// ****************************************
`define BFLE_FLAG_C 0
`define BFLE_FLAG_Z 1
`define BFLE_FLAG_N 2
`define BFLE_FLAG_V 3
`define BFLE_FLAG_S 4
`define BFLE_FLAG_H 5
`define BFLE_FLAG_T 6
`define BFLE_FLAG_I 7
`define BFLE_FLAGS_RST 8'h00
`define BFLE_CMD_RST 22'h000000
`define BFLE_ARG_RST 16'h0000

// ****************************************
// Pointer pair indices and execution cycle counts.
// ****************************************
`define BFLE_PAIR_X 4'hd
`define BFLE_PAIR_Y 4'he
`define BFLE_PAIR_Z 4'hf
`define BFLE_CYC_SHORT 2'h1
`define BFLE_CYC_LONG 2'h2

`endif

// ==== rtl/bfle_pkg.sv ====
// Types shared by the execution unit: operations, states, pointer choices.
// Assumes the constants header is compiled alongside.
package bfle_pkg;

  // ****************************************
  // Operation codes carried in the command word.
  // ****************************************
  typedef enum logic [4:0] {
    op_nop,
    op_io_bit_set,
    op_io_bit_clear,
    op_logical_shift_up,
    op_logical_shift_down,
    op_rotate_up_through_carry,
    op_rotate_down_through_carry,
    op_arithmetic_shift_down,
    op_nibble_swap,
    op_flag_set_by_index,
    op_flag_clear_by_index,
    op_bit_to_transfer_flag,
    op_transfer_flag_to_bit,
    op_register_copy,
    op_word_pair_copy,
    op_load_constant,
    op_pointer_load,
    op_pointer_offset_load,
    op_direct_address_load
  } bfle_op_t;

  // Sequencer states.
  typedef enum logic [1:0] {st_idle, st_first, st_second} bfle_state_t;

  // Pointer selection and pointer update mode.
  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} bfle_ptr_sel_t;
  typedef enum logic [1:0] {mode_plain, mode_post_inc, mode_pre_dec} bfle_ptr_mode_t;

endpackage

// ==== rtl/bfle_shifter.sv ====
// Shift, rotate and nibble exchange on one working register byte.
// Assumes the caller decides which of the returned flags to keep.
`timescale 1ns/1ps
`default_nettype none
module bfle_shifter
  import bfle_pkg::*;
(
  // Operation and operand.
  input wire bfle_op_t op,
  input wire logic [7:0] value,
  input wire logic carry_in,
  // Result and candidate flags.
  output logic [7:0] result,
  output logic carry_out,
  output logic zero_out,
  output logic negative_out,
  output logic overflow_out
);

  // ****************************************
  // Result and flag formation.
  // ****************************************
  // Overflow for a shift is negative xor carry, the signed sense of the move.
  always_comb begin
    result = value;
    carry_out = carry_in;
    case (op)
      op_logical_shift_up: begin
        result = {value[6:0], 1'b0};
        carry_out = value[7];
      end
      op_logical_shift_down: begin
        result = {1'b0, value[7:1]};
        carry_out = value[0];
      end
      op_rotate_up_through_carry: begin
        result = {value[6:0], carry_in};
        carry_out = value[7];
      end
      op_rotate_down_through_carry: begin
        result = {carry_in, value[7:1]};
        carry_out = value[0];
      end
      op_arithmetic_shift_down: begin
        result = {value[7], value[7:1]};
        carry_out = value[0];
      end
      op_nibble_swap: begin
        result = {value[3:0], value[7:4]};
      end
      default: begin
        result = value;
      end
    endcase
    zero_out = (result == 8'h00);
    negative_out = result[7];
    overflow_out = result[7] ^ carry_out;
  end

endmodule // bfle_shifter
`default_nettype wire

// ==== rtl/bfle_regfile.sv ====
// The 32 working registers, with one byte write port and one pair write port.
// Assumes writes from the sequencer and from the bus never target the same cycle.
`timescale 1ns/1ps
`default_nettype none
module bfle_regfile
  import bfle_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Byte write port, wins over the pair port on an overlapping byte.
  input wire logic byte_we,
  input wire logic [4:0] byte_addr,
  input wire logic [7:0] byte_data,
  // Pair write port, pair n covers registers 2n and 2n+1.
  input wire logic pair_we,
  input wire logic [3:0] pair_addr,
  input wire logic [15:0] pair_data,
  // All registers, read without delay.
  output logic [31:0][7:0] regs
);

  logic [7:0] mem [32];

  // ****************************************
  // One storage byte per register.
  // ****************************************
  // A load into a pointer byte during post-increment keeps the loaded data.
  generate
    for (genvar i = 0; i < 32; i++) begin : g_reg
      localparam logic [4:0] IDX = 5'(i);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem[i] <= 8'h00;
        end else if (byte_we && byte_addr == IDX) begin
          mem[i] <= byte_data;
        end else if (pair_we && pair_addr == IDX[4:1]) begin
          mem[i] <= IDX[0] ? pair_data[15:8] : pair_data[7:0];
        end
      end
      assign regs[i] = mem[i];
    end
  endgenerate

endmodule // bfle_regfile
`default_nettype wire

// ==== rtl/bfle_top.sv ====
// Execution unit for bit, flag, shift, move and load instructions, run by APB.
// Assumes data memory and I/O space answer in the same cycle as the strobe.
// What this block does
// - I/O set-bit forces bit one, two cycles
// - I/O clear-bit forces bit zero, two cycles
// - Shift up, zero in, flags, one cycle
// - Shift down, zero in, flags, one cycle
// - Rotate up through carry, one cycle
// - Rotate down through carry, one cycle
// - Arithmetic shift down keeps top bit
// - Set or clear any single flag
// - Interrupt enable set and clear, one cycle
// - Register bit copied into transfer flag
// - Transfer flag copied into register bit
// - Register copy, one cycle, flags kept
// - Pointer load then pointer plus one
// - Pointer minus one then load
// - Load at pointer plus offset, pointer kept
// - Direct address load, two cycles
`timescale 1ns/1ps
`default_nettype none
`include "bfle_consts.svh"
module bfle_top
  import bfle_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data memory read port.
  output logic mem_rd_en,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // I/O register space.
  output logic io_rd_en,
  output logic io_wr_en,
  output logic [4:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Global interrupt enable to the core.
  output logic global_int_en
);

  // ****************************************
  // Declarations.
  // ****************************************
  bfle_state_t state, next_state;
  logic [21:0] cmd;
  logic [15:0] arg;
  logic [7:0] status_flags, next_flags;
  logic [31:0][7:0] regs;
  logic byte_we, pair_we;
  logic [4:0] byte_addr;
  logic [7:0] byte_data;
  logic [3:0] pair_addr;
  logic [15:0] pair_data;
  logic ex_byte_we, ex_pair_we;
  logic [4:0] ex_byte_addr;
  logic [7:0] ex_byte_data;
  logic [15:0] ex_pair_data;
  logic [15:0] next_mem_addr;
  logic next_mem_rd;
  bfle_op_t op;
  bfle_ptr_sel_t ptr_sel;
  bfle_ptr_mode_t ptr_mode;
  logic [4:0] rd, rr;
  logic [2:0] bit_sel;
  logic [7:0] rd_val, rr_val, sh_res;
  logic [3:0] pair_idx;
  logic [15:0] ptr_val;
  logic sh_c, sh_z, sh_n, sh_v;
  logic access, hit_gpr, hit_reg, busy, refuse;
  logic [31:0] next_prdata;

  // Pair index of a pointer; displacement loads accept any of the three.
  function automatic logic [3:0] bfle_pair_of(input bfle_ptr_sel_t sel);
    case (sel)
      ptr_x: bfle_pair_of = `BFLE_PAIR_X;
      ptr_y: bfle_pair_of = `BFLE_PAIR_Y;
      default: bfle_pair_of = `BFLE_PAIR_Z;
    endcase
  endfunction

  // Number of execution cycles of an operation.
  function automatic logic [1:0] bfle_cycles(input bfle_op_t o);
    case (o)
      op_io_bit_set, op_io_bit_clear, op_pointer_load, op_pointer_offset_load,
      op_direct_address_load: bfle_cycles = `BFLE_CYC_LONG;
      default: bfle_cycles = `BFLE_CYC_SHORT;
    endcase
  endfunction

  // ****************************************
  // Command field decode.
  // ****************************************
  assign op = bfle_op_t'(cmd[`BFLE_CMD_OP_LSB +: 5]);
  assign rd = cmd[`BFLE_CMD_RD_LSB +: 5];
  assign rr = cmd[`BFLE_CMD_RR_LSB +: 5];
  assign bit_sel = cmd[`BFLE_CMD_BIT_LSB +: 3];
  assign ptr_sel = bfle_ptr_sel_t'(cmd[`BFLE_CMD_PTR_LSB +: 2]);
  assign ptr_mode = bfle_ptr_mode_t'(cmd[`BFLE_CMD_MODE_LSB +: 2]);
  assign rd_val = regs[rd];
  assign rr_val = regs[rr];
  assign pair_idx = bfle_pair_of(ptr_sel);
  assign ptr_val = {regs[{pair_idx, 1'b1}], regs[{pair_idx, 1'b0}]};
  assign busy = (state != st_idle);

  // ****************************************
  // APB decode and answer.
  // ****************************************
  // The slave waits one access cycle so that every answer comes from a flop.
  assign access = psel && penable && pready;
  assign hit_gpr = (paddr[11:7] == `BFLE_GPR_PAGE) && (paddr[1:0] == 2'b00);
  assign hit_reg = hit_gpr || paddr == `BFLE_OFF_CMD || paddr == `BFLE_OFF_ARG ||
                   paddr == `BFLE_OFF_FLAGS || paddr == `BFLE_OFF_STAT;
  // Writes while a command runs, other than to the status offset, are refused so state cannot change under it.
  assign refuse = !hit_reg || (pwrite && busy && paddr != `BFLE_OFF_STAT);

  always_comb begin
    next_prdata = 32'h00000000;
    if (hit_gpr) begin
      next_prdata = {24'h000000, regs[paddr[6:2]]};
    end else begin
      case (paddr)
        `BFLE_OFF_CMD: next_prdata = {10'h000, cmd};
        `BFLE_OFF_ARG: next_prdata = {16'h0000, arg};
        `BFLE_OFF_FLAGS: next_prdata = {24'h000000, status_flags};
        `BFLE_OFF_STAT: next_prdata = {31'h00000000, busy};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // Handshake: ready rises one cycle into the access phase and falls after it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= refuse;
      prdata <= pwrite ? 32'h00000000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Command and argument latches; a command word write starts execution.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= `BFLE_CMD_RST;
      arg <= `BFLE_ARG_RST;
    end else if (access && pwrite && !refuse) begin
      if (paddr == `BFLE_OFF_CMD) cmd <= pwdata[21:0];
      if (paddr == `BFLE_OFF_ARG) arg <= pwdata[15:0];
    end
  end

  // ****************************************
  // Sequencer.
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (access && pwrite && !refuse && paddr == `BFLE_OFF_CMD) next_state = st_first;
      end
      st_first: begin
        next_state = (bfle_cycles(op) == `BFLE_CYC_LONG) ? st_second : st_idle;
      end
      st_second: next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= st_idle;
    else state <= next_state;
  end

  // ****************************************
  // Execution: register writes, flags, memory address.
  // ****************************************
  always_comb begin
    ex_byte_we = 1'b0;
    ex_byte_addr = rd;
    ex_byte_data = rd_val;
    ex_pair_we = 1'b0;
    ex_pair_data = ptr_val;
    next_flags = status_flags;
    next_mem_rd = 1'b0;
    next_mem_addr = mem_addr;
    if (state == st_first) begin
      case (op)
        op_logical_shift_up, op_logical_shift_down, op_rotate_up_through_carry,
        op_rotate_down_through_carry, op_arithmetic_shift_down: begin
          ex_byte_we = 1'b1;
          ex_byte_data = sh_res;
          next_flags[`BFLE_FLAG_C] = sh_c;
          next_flags[`BFLE_FLAG_Z] = sh_z;
          next_flags[`BFLE_FLAG_N] = sh_n;
          next_flags[`BFLE_FLAG_V] = sh_v;
        end
        op_nibble_swap: begin
          ex_byte_we = 1'b1;
          ex_byte_data = sh_res;
        end
        op_flag_set_by_index: next_flags[bit_sel] = 1'b1;
        op_flag_clear_by_index: next_flags[bit_sel] = 1'b0;
        op_bit_to_transfer_flag: next_flags[`BFLE_FLAG_T] = rr_val[bit_sel];
        op_transfer_flag_to_bit: begin
          ex_byte_we = 1'b1;
          ex_byte_data[bit_sel] = status_flags[`BFLE_FLAG_T];
        end
        op_register_copy: begin
          ex_byte_we = 1'b1;
          ex_byte_data = rr_val;
        end
        op_word_pair_copy: begin
          ex_pair_we = 1'b1;
          ex_pair_data = {regs[{rr[4:1], 1'b1}], regs[{rr[4:1], 1'b0}]};
        end
        op_load_constant: begin
          ex_byte_we = 1'b1;
          ex_byte_data = arg[7:0];
        end
        op_pointer_load: begin
          next_mem_rd = 1'b1;
          next_mem_addr = ptr_val;
          if (ptr_mode == mode_pre_dec) begin
            next_mem_addr = ptr_val - 16'h0001;
            ex_pair_we = 1'b1;
            ex_pair_data = ptr_val - 16'h0001;
          end
        end
        op_pointer_offset_load: begin
          next_mem_rd = 1'b1;
          next_mem_addr = ptr_val + {10'h000, arg[5:0]};
        end
        op_direct_address_load: begin
          next_mem_rd = 1'b1;
          next_mem_addr = arg;
        end
        default: ex_byte_we = 1'b0;
      endcase
    end else if (state == st_second) begin
      if (op == op_pointer_load || op == op_pointer_offset_load || op == op_direct_address_load) begin
        ex_byte_we = 1'b1;
        ex_byte_data = mem_rdata;
      end
      if (op == op_pointer_load && ptr_mode == mode_post_inc) begin
        ex_pair_we = 1'b1;
        ex_pair_data = ptr_val + 16'h0001;
      end
    end
  end

  // Bus writes reach the registers only while idle, so the two never collide.
  assign byte_we = ex_byte_we || (access && pwrite && !refuse && hit_gpr);
  assign byte_addr = ex_byte_we ? ex_byte_addr : paddr[6:2];
  assign byte_data = ex_byte_we ? ex_byte_data : pwdata[7:0];
  assign pair_we = ex_pair_we;
  assign pair_addr = (op == op_word_pair_copy) ? rd[4:1] : pair_idx;
  assign pair_data = ex_pair_data;

  // Flags change from execution, or from software while idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_flags <= `BFLE_FLAGS_RST;
    else if (access && pwrite && !refuse && paddr == `BFLE_OFF_FLAGS) status_flags <= pwdata[7:0];
    else status_flags <= next_flags;
  end

  assign global_int_en = status_flags[`BFLE_FLAG_I];

  // Memory read strobe spans the second execution cycle only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_en <= 1'b0;
      mem_addr <= 16'h0000;
    end else begin
      mem_rd_en <= next_mem_rd;
      mem_addr <= next_mem_addr;
    end
  end

  // ****************************************
  // I/O read-modify-write, flags untouched.
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_rd_en <= 1'b0;
      io_wr_en <= 1'b0;
      io_addr <= 5'h00;
      io_wdata <= 8'h00;
    end else begin
      io_rd_en <= (state == st_first) && (op == op_io_bit_set || op == op_io_bit_clear);
      io_wr_en <= (state == st_second) && (op == op_io_bit_set || op == op_io_bit_clear);
      if (state == st_first) io_addr <= arg[4:0];
      if (state == st_second) begin
        io_wdata <= io_rdata;
        if (op == op_io_bit_set) io_wdata[bit_sel] <= 1'b1;
        if (op == op_io_bit_clear) io_wdata[bit_sel] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Leaf instances.
  // ****************************************
  bfle_shifter u_shifter (
    .op(op),
    .value(rd_val),
    .carry_in(status_flags[`BFLE_FLAG_C]),
    .result(sh_res),
    .carry_out(sh_c),
    .zero_out(sh_z),
    .negative_out(sh_n),
    .overflow_out(sh_v)
  );

  bfle_regfile u_regfile (
    .pclk(pclk),
    .presetn(presetn),
    .byte_we(byte_we),
    .byte_addr(byte_addr),
    .byte_data(byte_data),
    .pair_we(pair_we),
    .pair_addr(pair_addr),
    .pair_data(pair_data),
    .regs(regs)
  );

endmodule // bfle_top
`default_nettype wire

// ==== dv/bfle_mem_model.sv ====
// Behavioural data memory and I/O register space for the execution unit.
// Assumes both read ports are sampled by the design in their strobe cycle.
`timescale 1ns/1ps
`default_nettype none
module bfle_mem_model (
  // Clock.
  input wire logic pclk,
  // Data memory read port.
  input wire logic mem_rd_en,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  // I/O register space.
  input wire logic io_rd_en,
  input wire logic io_wr_en,
  input wire logic [4:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata
);
  logic [7:0] io_mem [32];
  logic [7:0] mem_last = 8'h00;
  logic [7:0] io_last = 8'h00;

  // Each I/O register starts with its own pattern.
  initial for (int n = 0; n < 32; n++) io_mem[n] = 8'(n * 17);

  // Idle lines show the inverse of the last answer, so stale data never matches.
  assign mem_rdata = mem_rd_en ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c) : ~mem_last;
  assign io_rdata = io_rd_en ? io_mem[io_addr] : ~io_last;

  // The unit samples I/O read data at the end of its strobe cycle; writes land at the strobe edge.
  always @(posedge pclk) begin
    if (mem_rd_en) mem_last <= mem_rdata;
    if (io_rd_en) io_last <= io_rdata;
    if (io_wr_en) io_mem[io_addr] <= io_wdata;
  end
endmodule // bfle_mem_model
`default_nettype wire

// ==== dv/bfle_sva.sv ====
// Concurrent checks on the execution unit's ports.
// Assumes it is bound to the top module by the statement below.
`timescale 1ns/1ps
`default_nettype none
`include "bfle_consts.svh"
module bfle_sva (
  // Clock, reset and APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Memory, I/O and interrupt enable.
  input wire logic mem_rd_en,
  input wire logic io_rd_en,
  input wire logic io_wr_en,
  input wire logic [4:0] io_addr,
  input wire logic global_int_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Sequences.
  // ****************************************
  sequence s_cmd(int lo, int hi);
    psel && penable && pready && pwrite && paddr == `BFLE_OFF_CMD && !pslverr
      && pwdata[4:0] >= lo && pwdata[4:0] <= hi;
  endsequence
  sequence s_int(int op);
    s_cmd(op, op) ##0 pwdata[17:15] == 3'h7;
  endsequence
  sequence s_load_pulse;
    !mem_rd_en ##1 !mem_rd_en ##1 mem_rd_en ##1 !mem_rd_en;
  endsequence

  // ****************************************
  // Properties.
  // ****************************************
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_read; pslverr && !pwrite |-> pready && prdata == 32'h0; endproperty
  property p_unmapped; psel && penable && pready && paddr == 12'h010 |-> pslverr; endproperty
  property p_load_time; s_cmd(16, 18) |-> s_load_pulse; endproperty
  property p_io_time; s_cmd(1, 2) |-> ##2 io_rd_en ##1 io_wr_en; endproperty
  property p_io_cause; io_wr_en |-> $past(io_rd_en) && $stable(io_addr); endproperty
  property p_short_quiet; s_cmd(3, 15) |=> (!mem_rd_en && !io_rd_en)[*3]; endproperty
  property p_int_on; s_int(9) |-> ##2 global_int_en; endproperty
  property p_int_off; s_int(10) |-> ##2 !global_int_en; endproperty
  property p_int_hold; s_cmd(1, 8) |=> $stable(global_int_en)[*2]; endproperty

  a_ready_wait: assert property (p_ready_wait) else $error("access phase length wrong");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  a_err_read: assert property (p_err_read) else $error("refused read data not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  a_load_time: assert property (p_load_time) else $error("load strobe timing wrong");
  a_io_time: assert property (p_io_time) else $error("io bit op timing wrong");
  a_io_cause: assert property (p_io_cause) else $error("io write without read");
  a_short_quiet: assert property (p_short_quiet) else $error("register op touched memory");
  a_int_on: assert property (p_int_on) else $error("interrupt enable not set");
  a_int_off: assert property (p_int_off) else $error("interrupt enable not cleared");
  a_int_hold: assert property (p_int_hold) else $error("interrupt enable disturbed");
endmodule // bfle_sva

bind bfle_top bfle_sva i_bfle_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_rd_en(mem_rd_en), .io_rd_en(io_rd_en), .io_wr_en(io_wr_en), .io_addr(io_addr),
  .global_int_en(global_int_en));
`default_nettype wire

// ==== dv/bfle_tb_top.sv ====
// Self-checking bench: APB tasks drive commands, results are read back.
// Assumes the memory model and the bound checker sit beside the design.
`timescale 1ns/1ps
`default_nettype none
`include "bfle_consts.svh"
module bfle_tb_top import bfle_pkg::*; ;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, mem_rd_en, io_rd_en, io_wr_en, global_int_en, e;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata, io_rdata, io_wdata, x;
  logic [4:0] io_addr;
  logic [8:0] r;
  logic [7:0] sv [3] = '{8'h80, 8'h01, 8'h96};
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  bfle_top i_bfle_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .io_rd_en(io_rd_en),
    .io_wr_en(io_wr_en), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_int_en(global_int_en));
  bfle_mem_model i_bfle_mem_model (.pclk(pclk), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .io_rd_en(io_rd_en), .io_wr_en(io_wr_en), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata));

  // ****************************************
  // Clock, timeout and helpers.
  // ****************************************
  initial forever #20 pclk = ~pclk;
  // A hung handshake would otherwise stall the run forever.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  function automatic logic [11:0] g(input int n);
    return 12'h080 + 12'(n * 4);
  endfunction
  function automatic logic [7:0] mval(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [31:0] cmd(input bfle_op_t op, input int rd, rr, b, p, m);
    return {10'h0, m[1:0], p[1:0], b[2:0], rr[4:0], rd[4:0], op};
  endfunction
  // Returns carry above the byte result.
  function automatic logic [8:0] shf(input int k, input logic [7:0] v, input logic ci);
    case (k)
      3: return {v[7], v[6:0], 1'h0};
      4: return {v[0], 1'h0, v[7:1]};
      5: return {v[7], v[6:0], ci};
      6: return {v[0], ci, v[7:1]};
      default: return {v[0], v[7], v[7:1]};
    endcase
  endfunction
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'h0, a, 32'h0);
    chk(33'({e, q[7:0]}), 33'({1'h0, exp}));
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] arg);
    apb(1'h1, `BFLE_OFF_ARG, arg);
    apb(1'h1, `BFLE_OFF_CMD, c);
    apb(1'h0, `BFLE_OFF_STAT, 32'h0);
    while (q[0] !== 1'h0) apb(1'h0, `BFLE_OFF_STAT, 32'h0);
  endtask

  // ****************************************
  // Scenarios.
  // ****************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rc(`BFLE_OFF_FLAGS, 8'h00);
    rc(g(5), 8'h00);
    apb(1'h0, 12'h010, 32'h0);
    chk({e, q}, {1'h1, 32'h0});
    // Every shift and rotate, with the top and bottom bit set in turn.
    foreach (sv[i]) for (int k = 3; k <= 7; k++) begin
      apb(1'h1, g(1), {24'h0, sv[i]});
      apb(1'h1, `BFLE_OFF_FLAGS, {28'h7, 3'h0, i[0]});
      run(cmd(bfle_op_t'(k), 1, 0, 0, 0, 0), 32'h0);
      r = shf(k, sv[i], i[0]);
      rc(g(1), r[7:0]);
      rc(`BFLE_OFF_FLAGS, {4'h7, r[8] ^ r[7], r[7], r[7:0] == 8'h0, r[8]});
    end
    // Each flag set then cleared on its own, interrupt enable included.
    apb(1'h1, `BFLE_OFF_FLAGS, 32'h0);
    x = 8'h00;
    for (int k = 0; k < 16; k++) begin
      run(cmd(k < 8 ? op_flag_set_by_index : op_flag_clear_by_index, 0, 0, k % 8, 0, 0), 32'h0);
      x[k % 8] = (k < 8);
      rc(`BFLE_OFF_FLAGS, x);
      chk(33'(global_int_en), 33'(x[7]));
    end
    // I/O bit operations at both ends of the space.
    apb(1'h1, `BFLE_OFF_FLAGS, 32'hff);
    run(cmd(op_io_bit_set, 0, 0, 7, 0, 0), 32'h0);
    run(cmd(op_io_bit_clear, 0, 0, 0, 0, 0), 32'h1f);
    chk(33'(i_bfle_mem_model.io_mem[0]), 33'h80);
    chk(33'(i_bfle_mem_model.io_mem[31]), 33'h0e);
    rc(`BFLE_OFF_FLAGS, 8'hff);
    // Transfer flag, swap, copies and constant.
    apb(1'h1, `BFLE_OFF_FLAGS, 32'h0);
    apb(1'h1, g(4), 32'ha5);
    apb(1'h1, g(6), 32'h0);
    run(cmd(op_bit_to_transfer_flag, 0, 4, 2, 0, 0), 32'h0);
    rc(`BFLE_OFF_FLAGS, 8'h40);
    run(cmd(op_transfer_flag_to_bit, 6, 0, 7, 0, 0), 32'h0);
    rc(g(6), 8'h80);
    run(cmd(op_nibble_swap, 4, 0, 0, 0, 0), 32'h0);
    rc(g(4), 8'h5a);
    run(cmd(op_register_copy, 7, 4, 0, 0, 0), 32'h0);
    rc(g(7), 8'h5a);
    run(cmd(op_load_constant, 12, 0, 0, 0, 0), 32'hc3);
    rc(g(12), 8'hc3);
    apb(1'h1, g(26), 32'hff);
    apb(1'h1, g(27), 32'h01);
    apb(1'h1, g(28), 32'h00);
    apb(1'h1, g(29), 32'h02);
    apb(1'h1, g(30), 32'h34);
    apb(1'h1, g(31), 32'h12);
    run(cmd(op_word_pair_copy, 8, 26, 0, 0, 0), 32'h0);
    rc(g(9), 8'h01);
    // Loads through each pointer; post-increment carries across the byte.
    run(cmd(op_pointer_load, 2, 0, 0, 0, 1), 32'h0);
    rc(g(2), mval(16'h01ff));
    rc(g(27), 8'h02);
    run(cmd(op_pointer_load, 3, 0, 0, 1, 2), 32'h0);
    rc(g(3), mval(16'h01ff));
    rc(g(28), 8'hff);
    run(cmd(op_pointer_load, 5, 0, 0, 2, 0), 32'h0);
    rc(g(5), mval(16'h1234));
    run(cmd(op_pointer_offset_load, 10, 0, 0, 2, 0), 32'h3f);
    rc(g(10), mval(16'h1273));
    rc(g(30), 8'h34);
    run(cmd(op_direct_address_load, 11, 0, 0, 0, 0), 32'hbeef);
    rc(g(11), mval(16'hbeef));
    rc(`BFLE_OFF_FLAGS, 8'h40);
    summarize();
  end
endmodule // bfle_tb_top
`default_nettype wire
